/* core/core_misc_instr_decode.sv */
// Purpose: Decodes and executes the configuration-load, idle and
//   return-from-interrupt instructions of an 8-bit core
// Assumes: Inputs synchronous to clk; core holds the next word while
//   instr_ready is low
// Notes: Status flags are never written by this block
//
// What this block does
// - Config-load copies accumulator into config register; flags untouched.
// - Config register is read and written at one file-register address.
// - Return-from-interrupt pops the stack and loads PC from stack top.
// - Return sets global interrupt enable, bit 7; flags untouched.
// - Return-from-interrupt is one word but takes two cycles.
`timescale 1ns/1ps
`include "misc_decode_consts.svh"

module core_misc_instr_decode #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7,
  parameter int PC_W = 13
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [`INSTR_W-1:0] instr_word,
  output logic instr_ready,
  input wire logic [DATA_W-1:0] acc_value,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic file_we,
  input wire logic file_re,
  input wire logic [DATA_W-1:0] file_wdata,
  output logic [DATA_W-1:0] file_rdata,
  output logic file_hit,
  input wire logic [PC_W-1:0] stack_top_entry,
  output logic stack_pop,
  output logic pc_load,
  output logic [PC_W-1:0] pc_load_value,
  output logic pc_advance,
  output logic irq_ctrl_set,
  output logic [DATA_W-1:0] irq_ctrl_set_mask,
  output logic global_irq_enable_set,
  output logic [DATA_W-1:0] cfg_value,
  output logic decoded_own
);

  // ==========================================================
  // Constants at the widths they meet
  localparam logic [1:0] RET_WAIT_LOAD = 2'(`RET_CYCLES - 1);
  localparam logic [DATA_W-1:0] IRQ_ENABLE_MASK =
    DATA_W'(1) << `IRQ_ENABLE_BIT;
  localparam logic [ADDR_W-1:0] CFG_ADDR = ADDR_W'(`CFG_FILE_ADDR);

  // ==========================================================
  // Decode
  misc_decode_pkg::instr_kind_type kind;
  wire is_cfg_load;
  wire is_idle;
  wire is_ret_irq;
  wire take;

  // Masked compare drops the two don't-care bits of the idle word
  assign is_idle = (instr_word & `IDLE_MASK) == `IDLE_MATCH;
  assign is_cfg_load = instr_word == `CFG_LOAD_WORD;
  assign is_ret_irq = instr_word == `RET_IRQ_WORD;

  // Any other word is still taken but leaves every output quiet
  always_comb begin
    kind = misc_decode_pkg::KIND_OTHER;
    if (is_cfg_load) begin
      kind = misc_decode_pkg::KIND_CFG_LOAD;
    end else if (is_ret_irq) begin
      kind = misc_decode_pkg::KIND_RET_IRQ;
    end else if (is_idle) begin
      kind = misc_decode_pkg::KIND_IDLE;
    end
  end

  // ==========================================================
  // Sequencer
  misc_decode_pkg::state_type state_q;
  misc_decode_pkg::state_type state_d;
  logic [1:0] wait_q;
  logic [1:0] wait_d;

  assign instr_ready = state_q == misc_decode_pkg::ST_READY;
  assign take = instr_valid && instr_ready;

  wire fire_cfg;
  wire fire_idle;
  wire fire_ret;
  wire wait_last;

  assign fire_cfg = take && (kind == misc_decode_pkg::KIND_CFG_LOAD);
  assign fire_idle = take && (kind == misc_decode_pkg::KIND_IDLE);
  assign fire_ret = take && (kind == misc_decode_pkg::KIND_RET_IRQ);
  assign wait_last = wait_q <= 2'h1;

  // Second cycle of the return holds off the next word while the
  // fetch path refills from the restored program counter
  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    unique case (state_q)
      misc_decode_pkg::ST_READY: begin
        if (fire_ret && (RET_WAIT_LOAD != 2'h0)) begin
          state_d = misc_decode_pkg::ST_RET_WAIT;
          wait_d = RET_WAIT_LOAD;
        end
      end
      misc_decode_pkg::ST_RET_WAIT: begin
        if (wait_last) begin
          state_d = misc_decode_pkg::ST_READY;
          wait_d = 2'h0;
        end else begin
          wait_d = wait_q - 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= misc_decode_pkg::ST_READY;
      wait_q <= 2'h0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
    end
  end

  // ==========================================================
  // Configuration register write port
  cfg_port_if #(.DATA_W(DATA_W)) cfg_port ();

  wire file_sel = file_addr == CFG_ADDR;
  wire file_cfg_wr = file_we && file_sel;

  // The dedicated load wins when both arrive in one cycle, since it is
  // the instruction being executed now
  assign cfg_port.we = fire_cfg || file_cfg_wr;
  assign cfg_port.wdata = fire_cfg ? acc_value : file_wdata;

  cfg_reg_store #(
    .DATA_W(DATA_W)
  ) u_cfg (
    .clk(clk),
    .nrst(nrst),
    .port(cfg_port)
  );

  assign cfg_value = cfg_port.value;

  // ==========================================================
  // File-register read path
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic hit_q;
  logic hit_d;

  // Unmapped addresses read as zero and leave file_hit low
  assign hit_d = file_re && file_sel;
  assign rdata_d = hit_d ? cfg_port.value : '0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= '0;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  assign file_rdata = rdata_q;
  assign file_hit = hit_q;

  // ==========================================================
  // Stack, program counter and interrupt-control outputs
  logic pop_q;
  logic pc_load_q;
  logic [PC_W-1:0] pc_val_q;
  logic [PC_W-1:0] pc_val_d;
  logic adv_q;
  logic adv_d;
  logic irq_en_q;
  logic own_q;
  logic own_d;

  // The captured target stands until the next return, so a slow core
  // may still load it after the pulse has gone
  assign pc_val_d = fire_ret ? stack_top_entry : pc_val_q;
  assign adv_d = fire_cfg || fire_idle;
  assign own_d = fire_cfg || fire_idle || fire_ret;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pop_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_val_q <= '0;
      adv_q <= 1'b0;
      irq_en_q <= 1'b0;
      own_q <= 1'b0;
    end else begin
      pop_q <= fire_ret;
      pc_load_q <= fire_ret;
      pc_val_q <= pc_val_d;
      adv_q <= adv_d;
      irq_en_q <= fire_ret;
      own_q <= own_d;
    end
  end

  assign stack_pop = pop_q;
  assign pc_load = pc_load_q;
  assign pc_load_value = pc_val_q;
  assign pc_advance = adv_q;
  // Set-only mask: other interrupt-control bits are never disturbed
  assign irq_ctrl_set = irq_en_q;
  assign irq_ctrl_set_mask = irq_en_q ? IRQ_ENABLE_MASK : '0;
  assign global_irq_enable_set = irq_en_q;
  assign decoded_own = own_q;

endmodule : core_misc_instr_decode

/* core/misc_decode_consts.svh */
// Purpose: Shared constants of the miscellaneous instruction decoder
// Assumes: 14-bit instruction words, 8-bit data path
// Notes: Definitions only
`ifndef MISC_DECODE_CONSTS_SVH
`define MISC_DECODE_CONSTS_SVH

// ==========================================================
// Instruction encodings
`define INSTR_W 14
`define CFG_LOAD_WORD 14'h0062
`define RET_IRQ_WORD 14'h0009
`define IDLE_MASK 14'h3f9f
`define IDLE_MATCH 14'h0000

// ==========================================================
// Field positions and timing
`define IRQ_ENABLE_BIT 7
`define RET_CYCLES 2

// ==========================================================
// Configuration register placement and reset
`define CFG_FILE_ADDR 7'h01
`define CFG_RESET 8'hff

`endif

/* core/misc_decode_pkg.sv */
// Purpose: Types of the miscellaneous instruction decoder
// Assumes: Nothing beyond the constants header
// Notes: Used by scoped name only
package misc_decode_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [0:0] {
    ST_READY,
    ST_RET_WAIT
  } state_type;

  // ==========================================================
  // Decoded instruction kinds
  typedef enum logic [1:0] {
    KIND_OTHER,
    KIND_CFG_LOAD,
    KIND_IDLE,
    KIND_RET_IRQ
  } instr_kind_type;

endpackage : misc_decode_pkg

/* core/cfg_port_if.sv */
// Purpose: Write port and value of the core configuration register
// Assumes: One writer, one holder
// Notes: Carried between the decoder and the register holder
`timescale 1ns/1ps

interface cfg_port_if #(
  parameter int DATA_W = 8
);
  logic we;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] value;

  modport ctrl (
    output we,
    output wdata,
    input value
  );

  modport store (
    input we,
    input wdata,
    output value
  );
endinterface : cfg_port_if

/* core/cfg_reg_store.sv */
// Purpose: Holds the core configuration register
// Assumes: Synchronous active-low reset
// Notes: Write takes effect at the next clock edge
`timescale 1ns/1ps
`include "misc_decode_consts.svh"

module cfg_reg_store #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  cfg_port_if.store port
);

  logic [DATA_W-1:0] cfg_q;
  logic [DATA_W-1:0] cfg_d;

  assign cfg_d = port.we ? port.wdata : cfg_q;
  assign port.value = cfg_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q <= DATA_W'(`CFG_RESET);
    end else begin
      cfg_q <= cfg_d;
    end
  end

endmodule : cfg_reg_store

/* tb/misc_decode_monitor.sv */
// Purpose: Port checks of the misc instruction decoder
// Assumes: Widths follow the bound decoder
// Notes: Bound to every decoder instance
`timescale 1ns/1ps
`include "misc_decode_consts.svh"
module misc_decode_monitor #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7,
  parameter int PC_W = 13
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [`INSTR_W-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic [DATA_W-1:0] acc_value,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic file_we,
  input wire logic file_re,
  input wire logic [DATA_W-1:0] file_wdata,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic file_hit,
  input wire logic [PC_W-1:0] stack_top_entry,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_value,
  input wire logic pc_advance,
  input wire logic irq_ctrl_set,
  input wire logic [DATA_W-1:0] irq_ctrl_set_mask,
  input wire logic global_irq_enable_set,
  input wire logic [DATA_W-1:0] cfg_value,
  input wire logic decoded_own
);
  // ======
  // Request decode and checks
  wire tk = instr_valid && instr_ready;
  wire ret = tk && instr_word == `RET_IRQ_WORD;
  wire load = tk && instr_word == `CFG_LOAD_WORD;
  wire idle = tk && (instr_word & `IDLE_MASK) == `IDLE_MATCH;
  // A same-cycle load wins, so file accesses are judged only without one
  wire sel = file_addr == ADDR_W'(`CFG_FILE_ADDR) && !load;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_load_copies_acc: assert property (
    load |=> cfg_value == $past(acc_value)) else $error("load lost acc");
  chk_file_write: assert property (
    file_we && sel |=> cfg_value == $past(file_wdata)) else $error("no write");
  chk_file_read: assert property (
    file_re && !file_we && sel |=> file_hit && file_rdata == $past(cfg_value))
    else $error("read wrong");
  chk_ret_pops_stack: assert property (
    ret |=> stack_pop && pc_load_value == $past(stack_top_entry))
    else $error("return did not pop");
  chk_ret_sets_enable: assert property (
    ret |=> global_irq_enable_set && irq_ctrl_set_mask == 8'h80)
    else $error("return left enable");
  chk_ret_two_cycles: assert property (
    ret |=> !instr_ready ##1 instr_ready) else $error("return length");
  chk_idle_only_pc: assert property (
    idle && !file_we |=> pc_advance && !stack_pop && $stable(cfg_value))
    else $error("idle changed state");
  chk_pop_needs_ret: assert property (
    stack_pop |-> $past(ret)) else $error("stray pop");
  chk_ret_pulse_set: assert property (
    ret |=> irq_ctrl_set && pc_load && decoded_own && !pc_advance)
    else $error("return pulses wrong");
  chk_foreign_word_ignored: assert property (
    tk && !ret && !load && !idle |=> !decoded_own && !pc_advance && !pc_load)
    else $error("foreign word executed");
endmodule : misc_decode_monitor
bind core_misc_instr_decode misc_decode_monitor #(
  .DATA_W(DATA_W),
  .ADDR_W(ADDR_W),
  .PC_W(PC_W)
) i_mon (
  .clk(clk),
  .nrst(nrst),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .instr_ready(instr_ready),
  .acc_value(acc_value),
  .file_addr(file_addr),
  .file_we(file_we),
  .file_re(file_re),
  .file_wdata(file_wdata),
  .file_rdata(file_rdata),
  .file_hit(file_hit),
  .stack_top_entry(stack_top_entry),
  .stack_pop(stack_pop),
  .pc_load(pc_load),
  .pc_load_value(pc_load_value),
  .pc_advance(pc_advance),
  .irq_ctrl_set(irq_ctrl_set),
  .irq_ctrl_set_mask(irq_ctrl_set_mask),
  .global_irq_enable_set(global_irq_enable_set),
  .cfg_value(cfg_value),
  .decoded_own(decoded_own)
);

/* tb/testbench.sv */
// Purpose: Directed bench for the misc instruction decoder
// Assumes: Default widths
// Notes: Inputs change on the falling clock edge
`timescale 1ns/1ps
`include "misc_decode_consts.svh"
module testbench;
  logic nrst, instr_ready, file_hit, stack_pop, pc_load, pc_advance;
  logic irq_ctrl_set, global_irq_enable_set, decoded_own;
  logic clk = 1'b0, instr_valid = 1'b0, file_we = 1'b0, file_re = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] acc_value = 8'h00, file_wdata = 8'h00;
  logic [7:0] file_rdata, irq_ctrl_set_mask, cfg_value;
  logic [6:0] file_addr = 7'h00;
  logic [12:0] stack_top_entry = 13'h0000, pc_load_value;
  int fails = 0, checks_done = 0;
  core_misc_instr_decode i_core_misc_instr_decode (
    .clk(clk),
    .nrst(nrst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .instr_ready(instr_ready),
    .acc_value(acc_value),
    .file_addr(file_addr),
    .file_we(file_we),
    .file_re(file_re),
    .file_wdata(file_wdata),
    .file_rdata(file_rdata),
    .file_hit(file_hit),
    .stack_top_entry(stack_top_entry),
    .stack_pop(stack_pop),
    .pc_load(pc_load),
    .pc_load_value(pc_load_value),
    .pc_advance(pc_advance),
    .irq_ctrl_set(irq_ctrl_set),
    .irq_ctrl_set_mask(irq_ctrl_set_mask),
    .global_irq_enable_set(global_irq_enable_set),
    .cfg_value(cfg_value),
    .decoded_own(decoded_own)
  );
  initial forever #4 clk = ~clk;
  // ======
  // Shared tasks and scenarios
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task go(input logic v, input logic [13:0] w);
    @(negedge clk);
    instr_valid = v;
    instr_word = w;
  endtask : go
  task final_report;
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task t_file;
    @(negedge clk);
    {file_we, file_addr, file_wdata} = {1'b1, `CFG_FILE_ADDR, 8'h5a};
    @(negedge clk);
    {file_we, file_re} = 2'b01;
    cmp(cfg_value, 8'h5a);
    @(negedge clk);
    file_addr = 7'h02;
    cmp({file_hit, file_rdata}, 9'h15a);
    @(negedge clk);
    file_re = 1'b0;
    cmp({file_hit, file_rdata}, 9'h000);
  endtask : t_file
  task t_cfg_load;
    go(1'b1, `CFG_LOAD_WORD);
    acc_value = 8'h3c;
    // Same-cycle file write must lose to the load
    {file_we, file_addr, file_wdata} = {1'b1, `CFG_FILE_ADDR, 8'h77};
    go(1'b1, `CFG_LOAD_WORD);
    {file_we, acc_value} = {1'b0, 8'ha5};
    cmp({cfg_value, pc_advance, decoded_own, stack_pop}, 11'h1e6);
    go(1'b0, `CFG_LOAD_WORD);
    cmp(cfg_value, 8'ha5);
  endtask : t_cfg_load
  task t_idle;
    acc_value = 8'h11;
    for (int i = 0; i < 4; i++) begin
      go(1'b1, 14'(i) << 5);
      go(1'b0, 14'h0008);
      cmp({pc_advance, decoded_own, pc_load, cfg_value}, 11'h6a5);
    end
    go(1'b1, 14'h0008);
    go(1'b0, 14'h0008);
    cmp({pc_advance, decoded_own, stack_pop}, 3'h0);
  endtask : t_idle
  task t_ret;
    go(1'b1, `RET_IRQ_WORD);
    stack_top_entry = 13'h1abc;
    go(1'b1, `IDLE_MATCH);
    stack_top_entry = 13'h0555;
    cmp({stack_pop, pc_load, pc_advance}, 3'h6);
    cmp({global_irq_enable_set, irq_ctrl_set_mask}, 9'h180);
    cmp({irq_ctrl_set, decoded_own}, 2'h3);
    cmp(instr_ready, 1'b0);
    go(1'b1, `IDLE_MATCH);
    cmp({instr_ready, stack_pop, pc_advance}, 3'h4);
    go(1'b0, `IDLE_MATCH);
    cmp({pc_advance, pc_load_value}, 14'h3abc);
  endtask : t_ret
  // Mid-run reset must restore the register and the captured target
  task t_reset;
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    cmp({instr_ready, cfg_value}, {1'b1, `CFG_RESET});
    cmp({stack_pop, pc_load_value}, 14'h0000);
    stack_top_entry = 13'h0123;
    go(1'b1, `RET_IRQ_WORD);
    go(1'b0, `RET_IRQ_WORD);
    cmp({stack_pop, pc_load_value}, 14'h2123);
  endtask : t_reset
  initial begin
    nrst = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    cmp({instr_ready, cfg_value}, {1'b1, `CFG_RESET});
    t_file();
    t_cfg_load();
    t_idle();
    t_ret();
    t_reset();
    final_report();
  end
  // Tests need about 35 cycles; 400 leaves room without hiding a hang
  initial begin
    #3200;
    fails++;
    final_report();
  end
endmodule : testbench
